//--- verilog/rcr_top.sv
`timescale 1ns/10ps
`include "rcr_map.svh"
module rcr_top
    import rcr_pkg::*;
#(
    parameter logic [23:0] PROT_LO = 24'h000200, // start of restricted range
    parameter logic [23:0] PROT_HI = 24'h0003FF  // end of restricted range
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        por_n,
    input  wire logic        bor_n,
    input  wire logic        master_clear_pin,
    input  wire logic        fetch_valid,
    input  wire logic [23:0] fetch_word,
    input  wire rcr_evt_t    core_evt,
    input  wire rcr_ptr_t    ptr_use,
    input  wire logic        wreg_wr,
    input  wire logic [3:0]  wreg_wr_idx,
    input  wire rcr_flow_t   flow,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             sys_reset,
    output logic             cold_reset,
    output logic      [23:0] pc_force,
    output logic             pc_load,
    output logic      [14:0] wreg_init
);

    // pin synchronisers, first stage read only by second
    logic [1:0] por_sync_ff;
    logic [1:0] bor_sync_ff;
    logic [1:0] master_clear_pin_sync_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            por_sync_ff  <= 2'h0;
            bor_sync_ff  <= 2'h0;
            master_clear_pin_sync_ff <= 2'h3;
        end else begin
            por_sync_ff  <= {por_sync_ff[0], por_n};
            bor_sync_ff  <= {bor_sync_ff[0], bor_n};
            master_clear_pin_sync_ff <= {master_clear_pin_sync_ff[0], master_clear_pin};
        end
    end

    // synchronised reset requests, active high
    wire por_req  = ~por_sync_ff[1];
    wire bor_req  = ~bor_sync_ff[1];
    wire pin_req  = ~master_clear_pin_sync_ff[1];
    wire cold_req = por_req | bor_req;

    // instruction is illegal when upper byte is the marker
    function automatic logic is_illegal(input logic [23:0] w);
        is_illegal = (w[23:16] == `RCR_ILLEGAL_OP);
    endfunction : is_illegal

    // target inside restricted protected range
    function automatic logic is_restricted(input logic [23:0] a);
        is_restricted = (a >= PROT_LO) && (a <= PROT_HI);
    endfunction : is_restricted

    // working-register initialised map, bit i for register i (stack pointer excluded)
    logic [14:0] winit_ff;
    logic [14:0] nxt_winit;

    wire illegal_op  = fetch_valid & is_illegal(fetch_word);
    wire uninit_ptr  = ptr_use.valid & (ptr_use.index != 4'hF)
                     & ~winit_ff[ptr_use.index[3:0]];
    wire flow_any    = flow.program_flow_change | flow.vector_flow_change;
    wire security    = flow_any & is_restricted(flow.target);
    wire illegal_any = illegal_op | uninit_ptr | security;

    // warm reset sources; register writes are not among them
    wire warm_req = illegal_any | core_evt.trap_conflict | core_evt.cfg_mismatch
                  | core_evt.sw_reset | core_evt.wdt_timeout | pin_req;
    wire any_req  = warm_req | cold_req;

    // register bus decode
    wire wr_status = reg_wr & (reg_addr == `RCR_ADDR_STATUS);

    // reset-cause flags
    logic [15:0] cause_ff;
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    logic [15:0] nxt_cause;

    // hardware set vector, every simultaneous cause recorded
    always_comb begin
        hw_set = 16'h0000;
        hw_set[`RCR_BIT_TRAP]     = core_evt.trap_conflict;
        hw_set[`RCR_BIT_ILLEGAL]  = illegal_any;
        hw_set[`RCR_BIT_CFGMIS]   = core_evt.cfg_mismatch;
        hw_set[`RCR_BIT_EXTPIN]   = pin_req;
        hw_set[`RCR_BIT_SWRST]    = core_evt.sw_reset;
        hw_set[`RCR_BIT_WDT]      = core_evt.wdt_timeout;
        hw_set[`RCR_BIT_SLEEP]    = core_evt.power_save_instruction_sleep;
        hw_set[`RCR_BIT_IDLE]     = core_evt.power_save_instruction_idle;
        hw_set[`RCR_BIT_BROWNOUT] = cold_req;
        hw_set[`RCR_BIT_POWERON]  = por_req;
    end

    // hardware clear vector
    always_comb begin
        hw_clr = 16'h0000;
        if (cold_req) begin
            // cold reset wipes all flags, the pin flag only on power-on
            hw_clr = `RCR_IMPL_MASK;
            hw_clr[`RCR_BIT_EXTPIN] = por_req;
        end
        if (core_evt.power_save_instruction_sleep | core_evt.power_save_instruction_idle | core_evt.wdt_clear) begin
            hw_clr[`RCR_BIT_WDT] = 1'b1;
        end
    end

    // software writes first, then hardware clear, then hardware set wins
    always_comb begin
        nxt_cause = cause_ff;
        if (wr_status) begin
            nxt_cause = reg_wdata & `RCR_IMPL_MASK;
        end
        nxt_cause = (nxt_cause & ~hw_clr) | hw_set;
    end

    // flags survive warm resets; asynchronous reset presets power state, as a power-on request also sets it (brown-out sets bit 1 only)
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cause_ff <= 16'h0003;
        end else begin
            cause_ff <= nxt_cause;
        end
    end

    // initialised map: any reset clears, write marks
    always_comb begin
        nxt_winit = winit_ff;
        if (wreg_wr && wreg_wr_idx != 4'hF) begin
            nxt_winit[wreg_wr_idx] = 1'b1;
        end
        if (any_req) begin
            nxt_winit = 15'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            winit_ff <= 15'h0000;
        end else begin
            winit_ff <= nxt_winit;
        end
    end

    // reset sequencer: hold while any request stands, then restart at zero
    rcr_state_t state_ff;
    rcr_state_t nxt_state;
    always_comb begin
        case (state_ff)
            RCR_RUN:  nxt_state = any_req ? RCR_HOLD : RCR_RUN;
            RCR_HOLD: nxt_state = any_req ? RCR_HOLD : RCR_RUN;
            default:  nxt_state = RCR_HOLD;
        endcase
    end

    logic sys_reset_ff;
    logic cold_ff;
    logic pc_load_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff     <= RCR_HOLD;
            sys_reset_ff <= 1'b1;
            cold_ff      <= 1'b1;
            pc_load_ff   <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            sys_reset_ff <= any_req;
            cold_ff      <= cold_req;
            // pc load on the release edge of the hold
            pc_load_ff   <= (state_ff == RCR_HOLD) && !any_req;
        end
    end

    // read data register, one cycle after strobe
    logic [15:0] rdata_ff;
    wire  [15:0] rd_mux = (reg_addr == `RCR_ADDR_STATUS) ? cause_ff :
                          (reg_addr == `RCR_ADDR_WINIT)  ? {1'b0, winit_ff} : 16'h0000;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign sys_reset  = sys_reset_ff;
    assign cold_reset = cold_ff;
    assign pc_force   = `RCR_RESET_PC;
    assign pc_load    = pc_load_ff;
    assign wreg_init  = winit_ff;

    // assertions
    sequence s_illegal_fetch;
        fetch_valid && fetch_word[23:16] == 8'h3F;
    endsequence

    chk_illegal_flag_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_illegal_fetch |=> cause_ff[14])
        else $error("illegal flag not set");
    chk_illegal_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_illegal_fetch |=> sys_reset)
        else $error("illegal opcode gave no reset");
    chk_uninit_ptr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ptr_use.valid && ptr_use.index != 4'hF && !wreg_init[ptr_use.index]) |=> sys_reset)
        else $error("uninitialised pointer gave no reset");
    chk_wreg_cleared: assert property (@(posedge sys_clk) disable iff (!rstn)
        sys_reset |-> wreg_init == 15'h0000)
        else $error("working registers not cleared");
    chk_security_rst: assert property (@(posedge sys_clk) disable iff (!rstn)
        ((flow.program_flow_change || flow.vector_flow_change) && flow.target >= PROT_LO && flow.target <= PROT_HI)
        |=> sys_reset && cause_ff[14])
        else $error("security reset missing");
    chk_trap_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        core_evt.trap_conflict |=> cause_ff[15] && sys_reset)
        else $error("trap flag missing");
    chk_cfg_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        core_evt.cfg_mismatch |=> cause_ff[9])
        else $error("mismatch flag missing");
    chk_pin_keep_bor: assert property (@(posedge sys_clk) disable iff (!rstn)
        (bor_req && !por_req && !wr_status && cause_ff[7]) |=> cause_ff[7])
        else $error("brown-out cleared pin flag");
    chk_wdt_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        (core_evt.wdt_clear && !core_evt.wdt_timeout) |=> !cause_ff[4])
        else $error("watchdog flag not cleared");
    chk_por_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
        (por_req && !core_evt.trap_conflict) |=> cause_ff[1:0] == 2'h3 && !cause_ff[15])
        else $error("power-on flags wrong");
    chk_sw_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_status && hw_set == 16'h0000 && hw_clr == 16'h0000)
        |=> cause_ff == ($past(reg_wdata) & 16'hC2DF))
        else $error("software write not stored");
    chk_pc_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(sys_reset) |-> pc_load && pc_force == 24'h000000)
        else $error("no restart at zero");
    chk_write_no_rst: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_status && !any_req) |=> !sys_reset)
        else $error("flag write caused reset");

    // flag clearing by cold resets; a cause firing in the same cycle still wins,
    // so each check leaves that cause out of its antecedent
    chk_trap_cold_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cold_req && !core_evt.trap_conflict) |=> !cause_ff[15])
        else $error("trap flag survived cold reset");
    chk_illegal_cold_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cold_req && !illegal_any) |=> !cause_ff[14])
        else $error("illegal flag survived cold reset");
    chk_cfg_cold_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cold_req && !core_evt.cfg_mismatch) |=> !cause_ff[9])
        else $error("mismatch flag survived cold reset");
    chk_swrst_cold_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cold_req && !core_evt.sw_reset) |=> !cause_ff[6])
        else $error("software reset flag survived cold reset");
    chk_wdt_cold_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cold_req && !core_evt.wdt_timeout) |=> !cause_ff[4])
        else $error("watchdog flag survived cold reset");
    chk_sleep_cold_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cold_req && !core_evt.power_save_instruction_sleep) |=> !cause_ff[3])
        else $error("sleep flag survived cold reset");
    chk_idle_cold_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cold_req && !core_evt.power_save_instruction_idle) |=> !cause_ff[2])
        else $error("idle flag survived cold reset");
    // each warm cause leaves its own flag and holds the core in reset
    chk_swrst_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        core_evt.sw_reset |=> cause_ff[6] && sys_reset)
        else $error("software reset flag missing");
    chk_wdt_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        core_evt.wdt_timeout |=> cause_ff[4] && sys_reset)
        else $error("watchdog flag missing");
    chk_pin_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        pin_req |=> cause_ff[7] && sys_reset)
        else $error("pin flag missing");
    chk_ptr_illegal_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        uninit_ptr |=> cause_ff[14])
        else $error("pointer fault left no illegal flag");
    // power-save records the mode and clears the watchdog flag; the core is not reset by it
    chk_sleep_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        core_evt.power_save_instruction_sleep |=> cause_ff[3])
        else $error("sleep flag missing");
    chk_idle_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        core_evt.power_save_instruction_idle |=> cause_ff[2])
        else $error("idle flag missing");
    // power-save also retires a stale watchdog flag; a fresh timeout wins
    chk_psave_wdt_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        ((core_evt.power_save_instruction_sleep || core_evt.power_save_instruction_idle) && !core_evt.wdt_timeout)
        |=> !cause_ff[4])
        else $error("power-save left watchdog flag");
    // among resets only a power-on clears the pin flag (a status write can too); pin and power-on together keep it
    chk_pin_por_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (por_req && !pin_req) |=> !cause_ff[7])
        else $error("power-on kept pin flag");
    // brown-out without power-on must not claim a power-on
    sequence s_brownout_only;
        bor_req && !por_req;
    endsequence
    chk_bor_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_brownout_only |=> cause_ff[1] && !cause_ff[0])
        else $error("brown-out flags wrong");
    // a hardware set beats a software clear landing in the same cycle
    chk_set_beats_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wr_status && hw_set != 16'h0000)
        |=> (cause_ff & $past(hw_set)) == $past(hw_set))
        else $error("software clear beat hardware set");
    // read port: data one cycle after the strobe, zero otherwise
    chk_status_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr == `RCR_ADDR_STATUS) |=> reg_rdata == $past(cause_ff))
        else $error("status read wrong");
    chk_winit_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        (reg_rd && reg_addr == `RCR_ADDR_WINIT) |=> reg_rdata == {1'b0, $past(wreg_init)})
        else $error("init map read wrong");
    chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data without strobe");
    // a written register becomes a legal pointer unless a reset lands with it
    chk_winit_mark: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wreg_wr && wreg_wr_idx != 4'hF && !any_req)
        |=> wreg_init[$past(wreg_wr_idx)])
        else $error("register write not marked");
    // cold requests are reported apart from warm ones
    chk_cold_out: assert property (@(posedge sys_clk) disable iff (!rstn)
        cold_req |=> sys_reset && cold_reset)
        else $error("cold reset not reported");
    chk_warm_not_cold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !cold_req |=> !cold_reset)
        else $error("warm reset reported as cold");
    // restart steps: hold ends, pc load pulses once at zero, then drops
    sequence s_hold_ends;
        sys_reset && !any_req;
    endsequence
    sequence s_restart;
        !sys_reset && pc_load ##1 !pc_load;
    endsequence
    chk_restart_seq: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_hold_ends |=> s_restart)
        else $error("restart sequence broken");
    chk_load_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
        pc_load |=> !pc_load)
        else $error("pc load longer than one cycle");
    chk_pc_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        pc_load |-> pc_force == `RCR_RESET_PC)
        else $error("restart address not zero");

endmodule : rcr_top

//--- verilog/rcr_map.svh
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH
// register index of the reset-cause status word
`define RCR_ADDR_STATUS   4'h0
// register index of the working-register initialised map (read only)
`define RCR_ADDR_WINIT    4'h1
// reset-cause bit positions
`define RCR_BIT_TRAP      15
`define RCR_BIT_ILLEGAL   14
`define RCR_BIT_CFGMIS    9
`define RCR_BIT_EXTPIN    7
`define RCR_BIT_SWRST     6
`define RCR_BIT_WDT       4
`define RCR_BIT_SLEEP     3
`define RCR_BIT_IDLE      2
`define RCR_BIT_BROWNOUT  1
`define RCR_BIT_POWERON   0
// implemented bits of the status word
`define RCR_IMPL_MASK     16'hC2DF
// illegal opcode upper byte
`define RCR_ILLEGAL_OP    8'h3F
// restart address
`define RCR_RESET_PC      24'h000000
`endif

//--- verilog/rcr_pkg.sv
package rcr_pkg;
    // fault and instruction events reported by the core, one-cycle pulses
    typedef struct packed {
        logic trap_conflict;
        logic cfg_mismatch;
        logic sw_reset;
        logic wdt_timeout;
        logic power_save_instruction_sleep;
        logic power_save_instruction_idle;
        logic wdt_clear;
    } rcr_evt_t;
    // pointer use by the core
    typedef struct packed {
        logic       valid;
        logic [3:0] index;
    } rcr_ptr_t;
    // flow change towards a target address
    typedef struct packed {
        logic        program_flow_change;
        logic        vector_flow_change;
        logic [23:0] target;
    } rcr_flow_t;
    // reset sequencer state
    typedef enum logic [1:0] {
        RCR_RUN,
        RCR_HOLD
    } rcr_state_t;
endpackage : rcr_pkg

//--- test/rcr_core_model.sv
`timescale 1ns/10ps
// core stand-in: fault, instruction, pointer and branch pulses
module rcr_core_model
    import rcr_pkg::*;
(
    input  wire logic   sys_clk,
    output rcr_evt_t    core_evt,
    output rcr_ptr_t    ptr_use,
    output logic        wreg_wr,
    output logic [3:0]  wreg_wr_idx,
    output rcr_flow_t   flow,
    output logic        fetch_valid,
    output logic [23:0] fetch_word
);
    // quiet at time zero
    initial begin
        core_evt    = '0;
        ptr_use     = '0;
        wreg_wr     = 1'b0;
        wreg_wr_idx = 4'h0;
        flow        = '0;
        fetch_valid = 1'b0;
        fetch_word  = 24'h000000;
    end
    // kind: 0 event, 1 fetch, 2 pointer, 3 reg write, 4 branch, 5 vector
    task automatic step(input logic [2:0] kind, input logic [23:0] arg);
        @(posedge sys_clk);
        core_evt    <= (kind == 3'h0) ? arg[6:0] : 7'h00;
        fetch_valid <= (kind == 3'h1);
        fetch_word  <= (kind == 3'h1) ? arg : ~arg;
        ptr_use     <= '{kind == 3'h2, arg[3:0]};
        wreg_wr     <= (kind == 3'h3);
        wreg_wr_idx <= arg[3:0];
        flow        <= '{kind == 3'h4, kind == 3'h5, arg};
        @(posedge sys_clk);
        // strobes drop; word flips so a stale fetch never looks fresh
        core_evt    <= 7'h00;
        fetch_valid <= 1'b0;
        fetch_word  <= ~fetch_word;
        ptr_use     <= '0;
        wreg_wr     <= 1'b0;
        flow        <= '0;
    endtask : step
endmodule : rcr_core_model

//--- test/reset_cause_recorder_bench.sv
`timescale 1ns/10ps
`include "rcr_map.svh"
module reset_cause_recorder_bench
    import rcr_pkg::*;
;
    localparam logic [23:0] LO = 24'h000200; // restricted range start
    localparam logic [23:0] HI = 24'h0003FF; // restricted range end
    // one row: preset, stimulus, expected status and reset
    typedef struct packed {
        logic [15:0] pre;
        logic [2:0]  kind;
        logic [23:0] arg;
        logic [15:0] st;
        logic        rs;
    } rcr_row_t;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        por_n = 1'b1;
    logic        bor_n = 1'b1;
    logic        master_clear_pin = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata, q;
    logic        sys_reset, cold_reset, pc_load, fetch_valid, wreg_wr;
    logic [23:0] pc_force, fetch_word;
    logic [14:0] wreg_init;
    logic [3:0]  wreg_wr_idx;
    rcr_evt_t    core_evt;
    rcr_ptr_t    ptr_use;
    rcr_flow_t   flow;
    int          mismatches = 0;
    int          n_compared = 0;
    rcr_row_t rows [15] = '{
        '{16'h0000, 3'h0, 24'h40, 16'h8000, 1'h1},
        '{16'h0000, 3'h0, 24'h20, 16'h0200, 1'h1},
        '{16'h0000, 3'h0, 24'h10, 16'h0040, 1'h1},
        '{16'h0000, 3'h0, 24'h08, 16'h0010, 1'h1},
        '{16'h0010, 3'h0, 24'h04, 16'h0008, 1'h0},
        '{16'h0010, 3'h0, 24'h02, 16'h0004, 1'h0},
        '{16'h0010, 3'h0, 24'h01, 16'h0000, 1'h0},
        '{16'h0000, 3'h1, 24'h3F0000, 16'h4000, 1'h1},
        '{16'h0000, 3'h1, 24'h3EFFFF, 16'h0000, 1'h0},
        '{16'h0000, 3'h2, 24'h3, 16'h4000, 1'h1},
        '{16'h0000, 3'h2, 24'hF, 16'h0000, 1'h0},
        '{16'h0000, 3'h4, LO, 16'h4000, 1'h1},
        '{16'h0000, 3'h4, LO - 24'h1, 16'h0000, 1'h0},
        '{16'h0000, 3'h5, HI, 16'h4000, 1'h1},
        '{16'h0000, 3'h5, HI + 24'h1, 16'h0000, 1'h0}
    };
    // 25 ns period
    always #12.5 sys_clk = ~sys_clk;
    rcr_top #(.PROT_LO(LO), .PROT_HI(HI)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .por_n(por_n), .bor_n(bor_n), .master_clear_pin(master_clear_pin),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word), .core_evt(core_evt),
        .ptr_use(ptr_use), .wreg_wr(wreg_wr), .wreg_wr_idx(wreg_wr_idx), .flow(flow),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sys_reset(sys_reset), .cold_reset(cold_reset),
        .pc_force(pc_force), .pc_load(pc_load), .wreg_init(wreg_init));
    rcr_core_model core (.sys_clk(sys_clk), .core_evt(core_evt), .ptr_use(ptr_use),
        .wreg_wr(wreg_wr), .wreg_wr_idx(wreg_wr_idx), .flow(flow),
        .fetch_valid(fetch_valid), .fetch_word(fetch_word));
    // shared compare
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    // wait for release, restart load must pulse as it falls
    task automatic settle();
        int i;
        #1;
        for (i = 0; i < 20; i++) begin
            if (sys_reset === 1'b0) break;
            @(posedge sys_clk);
            #1;
        end
        check({14'h0, sys_reset, pc_load}, 16'h1);
    endtask : settle
    // cold or pin request held five cycles, then released
    task automatic pins(input logic [2:0] m);
        @(posedge sys_clk);
        {por_n, bor_n, master_clear_pin} <= m;
        repeat (4) @(posedge sys_clk);
        #1;
        check(sys_reset, 1'h1);
        check(cold_reset, {1'h0, m[2:1] != 2'h3});
        @(posedge sys_clk);
        {por_n, bor_n, master_clear_pin} <= 3'h7;
        settle();
    endtask : pins
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // hang guard, far beyond the expected few hundred cycles
    initial begin
        #125000;
        mismatches++;
        stop_test();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        check(sys_reset, 1'h1);
        settle();
        check(pc_force[15:0], 16'h0);
        check(pc_force[23:8], 16'h0000);
        rd(`RCR_ADDR_STATUS, q);
        check(q, 16'h0003);
        foreach (rows[i]) begin
            wr(`RCR_ADDR_STATUS, rows[i].pre);
            core.step(rows[i].kind, rows[i].arg);
            #1;
            check(sys_reset, rows[i].rs);
            if (rows[i].rs) settle();
            rd(`RCR_ADDR_STATUS, q);
            check(q, rows[i].st);
        end
        // software sets every flag without a reset
        wr(`RCR_ADDR_STATUS, 16'hFFFF);
        repeat (3) @(posedge sys_clk);
        #1;
        check(sys_reset, 1'h0);
        rd(`RCR_ADDR_STATUS, q);
        check(q, `RCR_IMPL_MASK);
        rd(4'h7, q);
        check(q, 16'h0000);
        // clear collides with two causes at once; both must stick
        fork
            wr(`RCR_ADDR_STATUS, 16'h0000);
            core.step(3'h0, 24'h50);
        join
        settle();
        rd(`RCR_ADDR_STATUS, q);
        check(q, 16'h8040);
        // a written register may serve as pointer until the next reset
        core.step(3'h3, 24'h5);
        core.step(3'h2, 24'h5);
        #1;
        check({1'h0, wreg_init}, 16'h0020);
        rd(`RCR_ADDR_WINIT, q);
        check(q, 16'h0020);
        check(sys_reset, 1'h0);
        core.step(3'h0, 24'h10);
        settle();
        check({1'h0, wreg_init}, 16'h0000);
        // brown-out keeps the pin flag, pin sets it, power-on clears all
        wr(`RCR_ADDR_STATUS, `RCR_IMPL_MASK);
        pins(3'h5);
        rd(`RCR_ADDR_STATUS, q);
        check(q, 16'h0082);
        wr(`RCR_ADDR_STATUS, 16'h0000);
        pins(3'h6);
        rd(`RCR_ADDR_STATUS, q);
        check(q, 16'h0080);
        pins(3'h3);
        rd(`RCR_ADDR_STATUS, q);
        check(q, 16'h0003);
        stop_test();
    end
endmodule : reset_cause_recorder_bench
